// File: rtl/pirs_bus_if.sv
// Interface: the two open-drain wires between host and device
`timescale 1ns/1ns
interface pirs_bus_if;
    logic scl_oe_h;
    logic sda_oe_h;
    logic sda_oe_d;
    logic scl;
    logic sda;

    // Wired-AND with pull-ups: any enable pulls the wire low
    assign scl = ~scl_oe_h;
    assign sda = ~(sda_oe_h | sda_oe_d);

    modport host (output scl_oe_h, output sda_oe_h, input scl, input sda);
    modport dev (output sda_oe_d, input scl, input sda);
endinterface

// File: rtl/pirs_device.sv
// Device end: I2C register slave with register map and trigger deglitch
`timescale 1ns/1ns
module pirs_device
    import pirs_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
    parameter logic [2:0] DLY_PRESET = DLY_DEFAULT,
    parameter logic PWM1_ONLY = FPWM_DEFAULT,
    parameter logic PWM2_ONLY = FPWM_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    pirs_bus_if.dev bus,
    input wire logic die_hot,
    input wire logic [7:0] reg_good,
    input wire logic seq_trigger,
    output logic [7:0] regulator_enable_out,
    output logic [2:0] power_on_delay_select,
    output logic buck1_forced_pwm,
    output logic buck2_forced_pwm,
    output pirs_dly_t seq_delays,
    output logic seq_power_on,
    output logic seq_shutdown,
    output logic bus_busy
);

    localparam int SYNC_W = 12;
    localparam int DG_W = $clog2(DEGLITCH_CYCLES + 1);

    if (DEGLITCH_CYCLES < 2) begin
        $error("DEGLITCH_CYCLES must be at least 2");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_REG, S_PACK, S_WDATA, S_DACK,
        S_RDATA, S_MACK, S_IGNORE
    } pirs_dev_state_t;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_s;
    logic sda_s;
    logic hot_s;
    logic trig_s;
    logic [7:0] good_s;

    // Pins come from another domain; only the second stage is read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {bus.scl, bus.sda, die_hot, seq_trigger, reg_good};
            sync2_r <= sync1_r;
        end
    end

    assign scl_s = sync2_r[11];
    assign sda_s = sync2_r[10];
    assign hot_s = sync2_r[9];
    assign trig_s = sync2_r[8];
    assign good_s = sync2_r[7:0];

    // Idle bus is high, so the history starts high to avoid a false start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
        end
    end

    // ************************************************************
    // Bus events
    // ************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Slave progress is paced by edges of the master's clock, and by start and stop on the data line
    assign scl_rise = scl_s & ~scl_prev_r;
    assign scl_fall = ~scl_s & scl_prev_r;
    assign start_ev = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
    assign stop_ev = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

    // Busy flag spans start to stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_busy <= 1'b0;
        end else if (start_ev) begin
            bus_busy <= 1'b1;
        end else if (stop_ev) begin
            bus_busy <= 1'b0;
        end
    end

    // ************************************************************
    // Protocol engine
    // ************************************************************
    pirs_dev_state_t st_r;
    logic [3:0] cnt_r;
    pirs_byte_t shf_r;
    pirs_byte_t ptr_r;
    pirs_byte_t txd_r;
    pirs_byte_t rd_val;
    logic rw_r;
    logic mack_r;
    logic oe_r;

    assign bus.sda_oe_d = oe_r;

    // The data line only ever changes on a detected clock fall, which
    // lands a few cycles into the low phase at any legal rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= S_IDLE;
            cnt_r <= 4'h0;
            shf_r <= 8'h00;
            ptr_r <= 8'h00;
            txd_r <= 8'h00;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (start_ev) begin
            st_r <= S_ADDR;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (stop_ev) begin
            st_r <= S_IDLE;
            oe_r <= 1'b0;
        end else if (scl_rise) begin
            if (st_r inside {S_ADDR, S_REG, S_WDATA}) begin
                shf_r <= {shf_r[6:0], sda_s};
                cnt_r <= cnt_r + 4'h1;
            end else if (st_r == S_RDATA) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (st_r == S_MACK) begin
                mack_r <= ~sda_s;
            end
        end else if (scl_fall) begin
            unique case (st_r)
                S_ADDR: begin
                    if (cnt_r == 4'h8) begin
                        if (shf_r[7:1] == CHIP_ADDR) begin
                            st_r <= S_AACK;
                            oe_r <= 1'b1;
                            rw_r <= shf_r[0];
                        end else begin
                            st_r <= S_IGNORE;
                        end
                    end
                end
                S_AACK: begin
                    cnt_r <= 4'h0;
                    if (rw_r) begin
                        st_r <= S_RDATA;
                        txd_r <= rd_val;
                        oe_r <= ~rd_val[7];
                    end else begin
                        st_r <= S_REG;
                        oe_r <= 1'b0;
                    end
                end
                S_REG: begin
                    if (cnt_r == 4'h8) begin
                        ptr_r <= shf_r;
                        st_r <= S_PACK;
                        oe_r <= 1'b1;
                    end
                end
                S_PACK, S_DACK: begin
                    cnt_r <= 4'h0;
                    st_r <= S_WDATA;
                    oe_r <= 1'b0;
                end
                S_WDATA: begin
                    if (cnt_r == 4'h8) begin
                        st_r <= S_DACK;
                        oe_r <= 1'b1;
                    end
                end
                S_RDATA: begin
                    if (cnt_r == 4'h8) begin
                        st_r <= S_MACK;
                        oe_r <= 1'b0;
                    end else begin
                        oe_r <= ~txd_r[~cnt_r[2:0]];
                    end
                end
                S_MACK: begin
                    if (mack_r) begin
                        cnt_r <= 4'h0;
                        st_r <= S_RDATA;
                        txd_r <= rd_val;
                        oe_r <= ~rd_val[7];
                    end else begin
                        st_r <= S_IGNORE;
                    end
                end
                S_IDLE, S_IGNORE: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    pirs_byte_t regs_r [NUM_RW];
    logic wr_en;
    logic [3:0] wr_idx;

    // Constant, so the asynchronous reset branch loads only constants
    localparam pirs_byte_t SYSTEM_CONTROL_ONE_RST = SYSTEM_CONTROL_ONE_FIXED |
        {1'b0, DLY_PRESET, 1'b0, PWM2_ONLY, PWM1_ONLY, 1'b0};
    assign wr_en = scl_fall && st_r == S_WDATA && cnt_r == 4'h8;
    assign wr_idx = rw_index(ptr_r);

    // Masked write: status registers, unmapped and reserved bits hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_RW; i++) begin
                regs_r[i] <= (i == 0) ? SYSTEM_CONTROL_ONE_RST : RW_RESET[i];
            end
        end else if (wr_en && wr_idx != RW_NONE) begin
            regs_r[wr_idx] <= (regs_r[wr_idx] & ~RW_MASK[wr_idx]) |
                              (shf_r & RW_MASK[wr_idx]);
        end
    end

    // Read mux; status registers show live state
    always_comb begin
        rd_val = 8'h00;
        if (ptr_r == ADDR_INT_STATUS_A) begin
            rd_val[THERMAL_BIT] = hot_s;
        end else if (ptr_r == ADDR_REG_STATUS) begin
            rd_val = good_s & REG_STATUS_MASK;
        end else if (wr_idx != RW_NONE) begin
            rd_val = regs_r[wr_idx];
        end
    end

    assign regulator_enable_out = regs_r[1];
    assign power_on_delay_select = regs_r[0][DLY_LSB+2:DLY_LSB];
    assign buck1_forced_pwm = regs_r[0][BUCK1_FORCED_PWM_BIT];
    assign buck2_forced_pwm = regs_r[0][BUCK2_FORCED_PWM_BIT];

    // Decoded delays follow the preset field one cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_delays <= dly_decode(DLY_PRESET);
        end else begin
            seq_delays <= dly_decode(regs_r[0][DLY_LSB+2:DLY_LSB]);
        end
    end

    // ************************************************************
    // Sequencing trigger deglitch
    // ************************************************************
    logic [DG_W-1:0] dg_cnt_r;
    logic trig_r;

    // A new level must persist for the whole window before it counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dg_cnt_r <= '0;
            trig_r <= 1'b0;
            seq_power_on <= 1'b0;
            seq_shutdown <= 1'b0;
        end else begin
            seq_power_on <= 1'b0;
            seq_shutdown <= 1'b0;
            if (trig_s == trig_r) begin
                dg_cnt_r <= '0;
            end else if (dg_cnt_r == DG_W'(DEGLITCH_CYCLES - 1)) begin
                dg_cnt_r <= '0;
                trig_r <= trig_s;
                seq_power_on <= trig_s;
                seq_shutdown <= ~trig_s;
            end else begin
                dg_cnt_r <= dg_cnt_r + DG_W'(1);
            end
        end
    end

endmodule

// File: rtl/pirs_host.sv
// Host end: I2C master issuing single register writes and reads
`timescale 1ns/1ns
module pirs_host
    import pirs_pkg::*;
#(
    parameter int QUARTER_CYCLES = QTR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    pirs_bus_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_chip,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_nack
);

    localparam int Q_W = $clog2(QUARTER_CYCLES + 1);

    // Fewer cycles would exceed the maximum bit rate
    if (QUARTER_CYCLES < QTR_CYC) begin
        $error("QUARTER_CYCLES too small for the maximum bit rate");
    end

    typedef enum logic [3:0] {
        H_IDLE, H_START, H_ADDR, H_REG, H_DATA, H_RSTART, H_RADDR,
        H_RDATA, H_STOP
    } pirs_host_state_t;

    pirs_host_state_t st_r;
    logic [Q_W-1:0] tick_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    pirs_byte_t tx_r;
    pirs_byte_t rx_r;
    logic rd_r;
    logic [6:0] chip_r;
    pirs_byte_t reg_r;
    pirs_byte_t wdata_r;
    logic nack_r;
    logic [1:0] sda_sync_r;
    logic sda_s;
    logic op_end;
    logic scl_low_nxt;
    logic sda_low_nxt;

    assign cmd_ready = (st_r == H_IDLE);
    assign sda_s = sda_sync_r[1];
    assign op_end = (q_r == 2'h3) && (tick_r == Q_W'(QUARTER_CYCLES - 1));

    // Data line from the far end is synchronised before sampling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_sync_r <= 2'h3;
        end else begin
            sda_sync_r <= {sda_sync_r[0], bus.sda};
        end
    end

    // ************************************************************
    // Wire drive per quarter of each bit
    // ************************************************************
    always_comb begin
        scl_low_nxt = 1'b0;
        sda_low_nxt = 1'b0;
        unique case (st_r)
            H_START, H_RSTART: begin
                scl_low_nxt = (q_r == 2'h0);
                sda_low_nxt = q_r[1];
            end
            H_STOP: begin
                scl_low_nxt = (q_r == 2'h0);
                sda_low_nxt = ~q_r[1];
            end
            H_ADDR, H_REG, H_DATA, H_RADDR: begin
                scl_low_nxt = ~q_r[1];
                sda_low_nxt = (bit_r < 4'h8) && ~tx_r[~bit_r[2:0]];
            end
            H_RDATA: begin
                scl_low_nxt = ~q_r[1];
            end
            H_IDLE: begin
            end
        endcase
    end

    // Registered so the open-drain enables never glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.scl_oe_h <= 1'b0;
            bus.sda_oe_h <= 1'b0;
        end else begin
            bus.scl_oe_h <= scl_low_nxt;
            bus.sda_oe_h <= sda_low_nxt;
        end
    end

    // Quarter timer sets the bit rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_r <= '0;
            q_r <= 2'h0;
        end else if (st_r == H_IDLE) begin
            tick_r <= '0;
            q_r <= 2'h0;
        end else if (tick_r == Q_W'(QUARTER_CYCLES - 1)) begin
            tick_r <= '0;
            q_r <= q_r + 2'h1;
        end else begin
            tick_r <= tick_r + Q_W'(1);
        end
    end

    // ************************************************************
    // Transfer sequencer
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= H_IDLE;
            bit_r <= 4'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            rd_r <= 1'b0;
            chip_r <= 7'h00;
            reg_r <= 8'h00;
            wdata_r <= 8'h00;
            nack_r <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_nack <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (st_r == H_IDLE) begin
                if (cmd_valid) begin
                    st_r <= H_START;
                    rd_r <= cmd_read;
                    chip_r <= cmd_chip;
                    reg_r <= cmd_reg;
                    wdata_r <= cmd_wdata;
                    nack_r <= 1'b0;
                    rx_r <= 8'h00;
                end
            end else if (op_end) begin
                bit_r <= 4'h0;
                if (st_r == H_START) begin
                    st_r <= H_ADDR;
                    tx_r <= {chip_r, 1'b0};
                end else if (st_r == H_RSTART) begin
                    st_r <= H_RADDR;
                    tx_r <= {chip_r, 1'b1};
                end else if (st_r == H_STOP) begin
                    st_r <= H_IDLE;
                    rsp_valid <= 1'b1;
                    rsp_rdata <= rx_r;
                    rsp_nack <= nack_r;
                end else if (bit_r < 4'h8) begin
                    bit_r <= bit_r + 4'h1;
                    if (st_r == H_RDATA) begin
                        rx_r <= {rx_r[6:0], sda_s};
                    end
                end else if (st_r == H_RDATA) begin
                    st_r <= H_STOP;
                end else if (sda_s) begin
                    nack_r <= 1'b1;
                    st_r <= H_STOP;
                end else if (st_r == H_ADDR) begin
                    st_r <= H_REG;
                    tx_r <= reg_r;
                end else if (st_r == H_REG) begin
                    st_r <= rd_r ? H_RSTART : H_DATA;
                    tx_r <= wdata_r;
                end else if (st_r == H_RADDR) begin
                    st_r <= H_RDATA;
                end else begin
                    st_r <= H_STOP;
                end
            end
        end
    end

endmodule

// File: rtl/pirs_pkg.sv
// Package: constants, register map and decode functions of the I2C slave
package pirs_pkg;

    typedef logic [7:0] pirs_byte_t;
    typedef logic [19:0] pirs_dly_t;

    // ************************************************************
    // Link and timing
    // ************************************************************
    localparam logic [6:0] CHIP_ADDR = 7'h59;
    localparam int CLK_NS = 100;
    localparam int MAX_KBPS = 400;
    localparam int BIT_NS = 1000000 / MAX_KBPS;
    // Quarter of a bit, rounded up so the rate never exceeds the limit
    localparam int QTR_CYC = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam int DEGLITCH_US = 1000;
    localparam int DEGLITCH_CYC = DEGLITCH_US * 1000 / CLK_NS;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam pirs_byte_t ADDR_INT_STATUS_A = 8'h02;
    localparam pirs_byte_t ADDR_SYS_CTRL_ONE = 8'h07;
    localparam pirs_byte_t ADDR_REG_ENABLE = 8'h10;
    localparam pirs_byte_t ADDR_REG_STATUS = 8'h11;
    localparam pirs_byte_t ADDR_VOLT_CHANGE = 8'h20;
    localparam pirs_byte_t ADDR_B1_TV_A = 8'h23;
    localparam pirs_byte_t ADDR_B1_TV_B = 8'h24;
    localparam pirs_byte_t ADDR_B1_RAMP = 8'h25;
    localparam pirs_byte_t ADDR_B2_TV_A = 8'h29;
    localparam pirs_byte_t ADDR_B2_TV_B = 8'h2a;
    localparam pirs_byte_t ADDR_B2_RAMP = 8'h2b;
    localparam pirs_byte_t ADDR_BUCK_FUNC = 8'h38;
    localparam pirs_byte_t ADDR_LDO1_VCTRL = 8'h39;
    localparam pirs_byte_t ADDR_LDO2_VCTRL = 8'h3a;

    localparam int THERMAL_BIT = 1;
    localparam pirs_byte_t REG_STATUS_MASK = 8'hf5;
    localparam int DLY_LSB = 4;
    localparam int BUCK2_FORCED_PWM_BIT = 2;
    localparam int BUCK1_FORCED_PWM_BIT = 1;
    localparam logic [2:0] DLY_DEFAULT = 3'h2;
    localparam logic FPWM_DEFAULT = 1'b1;
    // Fixed part of system control one: D3 reads one, D7 and D0 zero
    localparam pirs_byte_t SYSTEM_CONTROL_ONE_FIXED = 8'h08;

    // Writable registers; entry 0 is system control one
    localparam int NUM_RW = 12;
    localparam logic [3:0] RW_NONE = 4'hf;
    localparam pirs_byte_t RW_ADDR [NUM_RW] = '{
        ADDR_SYS_CTRL_ONE, ADDR_REG_ENABLE, ADDR_VOLT_CHANGE, ADDR_B1_TV_A,
        ADDR_B1_TV_B, ADDR_B1_RAMP, ADDR_B2_TV_A, ADDR_B2_TV_B,
        ADDR_B2_RAMP, ADDR_BUCK_FUNC, ADDR_LDO1_VCTRL, ADDR_LDO2_VCTRL};
    localparam pirs_byte_t RW_MASK [NUM_RW] = '{
        8'h76, 8'h55, 8'h33, 8'h3f, 8'h3f, 8'hff,
        8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam pirs_byte_t RW_RESET [NUM_RW] = '{
        8'h00, 8'h75, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Index of a writable register, RW_NONE for anything else
    function automatic logic [3:0] rw_index(input pirs_byte_t a);
        logic [3:0] idx;
        idx = RW_NONE;
        for (int i = 0; i < NUM_RW; i++) begin
            if (RW_ADDR[i] == a) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Delays in half milliseconds: buck1, buck2, ldo1, ldo2 from the top
    function automatic pirs_dly_t dly_decode(input logic [2:0] code);
        pirs_dly_t d;
        d = {5'h02, 5'h02, 5'h02, 5'h02};
        unique case (code)
            3'h0: d = {5'h02, 5'h02, 5'h02, 5'h02};
            3'h1: d = {5'h02, 5'h03, 5'h04, 5'h04};
            3'h2: d = {5'h03, 5'h04, 5'h06, 5'h0c};
            3'h3: d = {5'h03, 5'h04, 5'h02, 5'h02};
            3'h4: d = {5'h03, 5'h04, 5'h06, 5'h0c};
            3'h5: d = {5'h03, 5'h03, 5'h04, 5'h04};
            3'h6: d = {5'h06, 5'h04, 5'h02, 5'h03};
            3'h7: d = {5'h04, 5'h06, 5'h0c, 5'h16};
        endcase
        return d;
    endfunction

endpackage

// File: tb/pirs_asserts.sv
// Checker: wire-level assertions on the device end of the serial link
`timescale 1ns/1ns
module pirs_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_d
);
    logic scl_q, sda_q, idle_r, ign_r, hit_r, rd_r;
    logic [5:0] nrise_r;
    logic [7:0] sh_r;
    wire logic rise = scl & ~scl_q;
    wire logic start = scl & scl_q & sda_q & ~sda;
    wire logic stop = scl & scl_q & ~sda_q & sda;
    // Wire one sample back; released bus idles high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {scl_q, sda_q} <= 2'h3;
        else {scl_q, sda_q} <= {scl, sda};
    end
    // Clock rises since the last start, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) nrise_r <= 6'h00;
        else if (start) nrise_r <= 6'h00;
        else if (rise && nrise_r != 6'h3f) nrise_r <= nrise_r + 6'h01;
    end
    // Bits taken on clock rises, as the device should
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sh_r <= 8'h00;
        else if (rise) sh_r <= {sh_r[6:0], sda};
    end
    // Transfer state judged from the address byte alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {idle_r, ign_r, hit_r, rd_r} <= 4'h8;
        else if (stop) {idle_r, ign_r, hit_r, rd_r} <= 4'h8;
        else if (start) {idle_r, ign_r, hit_r, rd_r} <= 4'h0;
        else if (rise && nrise_r == 6'h08)
            {ign_r, hit_r, rd_r} <= {sh_r[7:1] != 7'h59,
                sh_r[7:1] == 7'h59, sh_r[0]};
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ninth;
        rise && nrise_r == 6'h08;
    endsequence
    a_addr_ack: assert property (s_ninth |-> sda_oe_d == (sh_r[7:1] == 7'h59))
        else $error("address acknowledge wrong");
    a_addr_quiet: assert property (!idle_r && nrise_r < 6'h08 |-> !sda_oe_d)
        else $error("device drove during address byte");
    a_write_ack: assert property (rise && hit_r && !rd_r &&
        (nrise_r == 6'h11 || nrise_r == 6'h1a) |-> sda_oe_d)
        else $error("write byte not acknowledged");
    a_read_release: assert property (rise && hit_r && rd_r &&
        nrise_r == 6'h11 |-> !sda_oe_d)
        else $error("device held data in master slot");
    a_data_steady: assert property (scl && scl_q |-> $stable(sda_oe_d))
        else $error("device data moved while clock high");
    a_change_low: assert property ($changed(sda_oe_d) |-> !scl)
        else $error("device data changed with clock high");
    a_free_quiet: assert property ($rose(idle_r) |-> !sda_oe_d [*8])
        else $error("device drove after stop");
    a_ignore_quiet: assert property (ign_r |-> !sda_oe_d)
        else $error("device drove after foreign address");
endmodule

// File: tb/pmic_i2c_register_slave_tb.sv
// Testbench: host and device ends joined, register traffic over the link
`timescale 1ns/1ns
module pmic_i2c_register_slave_tb import pirs_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0;
    logic die_hot = 1'b0, seq_trigger = 1'b0, busy_seen = 1'b0;
    logic cmd_ready, rsp_valid, rsp_nack, bus_busy, seq_power_on;
    logic seq_shutdown, b1_pwm, b2_pwm;
    logic [6:0] cmd_chip = 7'h59;
    logic [7:0] cmd_reg = 8'h00, cmd_wdata = 8'h00, reg_good = 8'hff;
    logic [7:0] rsp_rdata, en_out;
    logic [2:0] dly_sel, c;
    pirs_dly_t delays;
    int fail_count = 0, cmp_count = 0, cyc = 0, k;
    localparam logic [7:0] RA [14] = '{8'h02, 8'h07, 8'h10, 8'h11, 8'h20,
        8'h23, 8'h24, 8'h25, 8'h29, 8'h2a, 8'h2b, 8'h38, 8'h39, 8'h3a};
    // Status entries hold the live value the bench sets
    localparam logic [7:0] RS [14] = '{1: 8'h2e, 2: 8'h75, 3: 8'hf5,
        default: 8'h00};
    localparam logic [7:0] RM [14] = '{1: 8'h76, 2: 8'h55, 4: 8'h33,
        5: 8'h3f, 6: 8'h3f, 8: 8'h3f, 9: 8'h3f, 0: 8'h00, 3: 8'h00,
        default: 8'hff};
    always #50 clk = ~clk;
    pirs_bus_if bus_if ();
    pirs_host #(.QUARTER_CYCLES(7)) pirs_host_inst (.clk(clk), .rst(rst),
        .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_chip(cmd_chip), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_nack(rsp_nack));
    pirs_device #(.DEGLITCH_CYCLES(20)) pirs_device_inst (.clk(clk),
        .rst(rst), .bus(bus_if.dev), .die_hot(die_hot), .reg_good(reg_good),
        .seq_trigger(seq_trigger), .regulator_enable_out(en_out),
        .power_on_delay_select(dly_sel), .buck1_forced_pwm(b1_pwm),
        .buck2_forced_pwm(b2_pwm), .seq_delays(delays),
        .seq_power_on(seq_power_on), .seq_shutdown(seq_shutdown),
        .bus_busy(bus_busy));
    pirs_asserts pirs_asserts_inst (.clk(clk), .rst(rst), .scl(bus_if.scl),
        .sda(bus_if.sda), .sda_oe_d(bus_if.sda_oe_d));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [19:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One command; inputs move only at falling edges
    task automatic xfer(input logic rd, input logic [6:0] chip,
            input logic [7:0] ra, input logic [7:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) @(negedge clk);
        {cmd_valid, cmd_read, cmd_chip, cmd_reg, cmd_wdata} =
            {1'b1, rd, chip, ra, wd};
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            busy_seen |= bus_busy;
            n++;
        end
        chk("response", 20'(rsp_valid), 20'h1);
    endtask
    // Bounded wait for a sequencing pulse; 80 means none came
    task automatic wait_pulse(input logic sel);
        k = 0;
        while ((sel ? seq_shutdown : seq_power_on) !== 1'b1 && k < 80) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Main sequence: reset values, write masks, faults, decode, trigger
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("defaults", 20'({dly_sel, b2_pwm, b1_pwm}), 20'h0b);
        chk("delays", delays, {5'h03, 5'h04, 5'h06, 5'h0c});
        chk("enables", 20'(en_out), 20'h75);
        for (int i = 0; i < 14; i++) begin
            xfer(1'b1, 7'h59, RA[i], 8'h00);
            chk("reset_value", 20'(rsp_rdata), 20'(RS[i]));
            xfer(1'b0, 7'h59, RA[i], 8'h5a);
            chk("write_ack", 20'(rsp_nack), 20'h0);
            xfer(1'b1, 7'h59, RA[i], 8'h00);
            chk("readback", 20'(rsp_rdata),
                20'((RS[i] & ~RM[i]) | (8'h5a & RM[i])));
        end
        {die_hot, reg_good} = {1'b1, 8'h0e};
        xfer(1'b1, 7'h59, 8'h02, 8'h00);
        chk("thermal", 20'(rsp_rdata), 20'h02);
        xfer(1'b1, 7'h59, 8'h11, 8'h00);
        chk("reg_status", 20'(rsp_rdata), 20'h04);
        xfer(1'b0, 7'h59, 8'h05, 8'hff);
        xfer(1'b1, 7'h59, 8'h05, 8'h00);
        chk("unmapped", 20'({rsp_nack, rsp_rdata}), 20'h0);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b0, i ? 7'h19 : 7'h58, 8'h25, 8'h00);
            chk("foreign_chip", 20'(rsp_nack), 20'h1);
        end
        xfer(1'b1, 7'h59, 8'h25, 8'h00);
        chk("untouched", 20'(rsp_rdata), 20'h5a);
        for (int j = 0; j < 2; j++) begin
            c = j ? 3'h7 : 3'h0;
            xfer(1'b0, 7'h59, 8'h07, {1'b0, c, 1'b0, c[0], ~c[0], 1'b0});
            chk("sys_ctrl", 20'({dly_sel, b2_pwm, b1_pwm}),
                20'({c, c[0], ~c[0]}));
            chk("decode", delays, j ? {5'h04, 5'h06, 5'h0c, 5'h16}
                : {4{5'h02}});
        end
        chk("busy", 20'({busy_seen, bus_busy}), 20'h2);
        seq_trigger = 1'b1;
        repeat (5) @(negedge clk);
        seq_trigger = 1'b0;
        wait_pulse(1'b0);
        chk("glitch", 20'(k == 80), 20'h1);
        seq_trigger = 1'b1;
        wait_pulse(1'b0);
        chk("power_on", 20'(k >= 20 && k < 80), 20'h1);
        seq_trigger = 1'b0;
        wait_pulse(1'b1);
        chk("shutdown", 20'(k >= 20 && k < 80), 20'h1);
        give_verdict();
    end
endmodule
